// ==== src/msmclk_dev.sv ====
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module msmclk_dev (
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_sys_rst,
  // Channel inputs: signed codes, full scale is +-2.5 V
  input  wire logic [msmclk_pkg::NUM_CH-1:0][msmclk_pkg::IN_W-1:0] i_ch_level,
  // Link to the filter
  msmclk_if.dev                               link
);
  localparam int N = msmclk_pkg::NUM_CH;
  localparam int W = msmclk_pkg::IN_W;
  localparam int A = msmclk_pkg::ACC_W;

  logic [7:0] osc_cnt_q;
  logic       osc_q;
  logic       src_q;
  logic       src_d;
  logic       mclk_q;
  logic       mclk_rise;
  logic [N-1:0] bit_q;

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator, free running
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_cnt_q <= 8'h00;
      osc_q     <= 1'b0;
    end else if (osc_cnt_q == 8'(msmclk_pkg::OSC_PER_CYC - 1)) begin
      osc_cnt_q <= 8'h00;
      osc_q     <= 1'b1;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
      // Whole period kept exact; duty is uneven by one clock
      if (osc_cnt_q == 8'(msmclk_pkg::OSC_HI_CYC - 1)) begin
        osc_q <= 1'b0;
      end
    end
  end

  // Source mux; external pin is taken as synchronous
  assign src_d = link.clock_source_select ? osc_q
                                          : link.external_clock_input;

  ////////////////////////////////////////////////////////////////////////////
  // Divide by two on source rising edges
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      src_q  <= 1'b0;
      mclk_q <= 1'b0;
    end else begin
      src_q <= src_d;
      if (src_d && !src_q) begin
        mclk_q <= ~mclk_q;
      end
    end
  end

  assign mclk_rise = src_d && !src_q && !mclk_q;
  assign link.modulator_clock_output = mclk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Second-order modulators, one per channel
  for (genvar c = 0; c < N; c++) begin : g_ch
    logic signed [A-1:0] int1_q;
    logic signed [A-1:0] int2_q;
    logic signed [A-1:0] fb;
    logic signed [A-1:0] x;
    logic signed [A-1:0] i1n;
    logic signed [A-1:0] i2n;
    // Input scaled by 3/4 so +2 V of 2.5 gives 80 percent ones
    assign fb  = bit_q[c] ? A'(2**(W-1)) : -A'(2**(W-1));
    assign x   = A'((A'($signed(i_ch_level[c])) * 3) >>> 2);
    assign i1n = int1_q + x - fb;
    assign i2n = int2_q + i1n - fb;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        int1_q   <= '0;
        int2_q   <= '0;
        bit_q[c] <= 1'b0;
      end else if (mclk_rise) begin
        int1_q   <= i1n;
        int2_q   <= i2n;
        // Comparator; the new bit is fed back next clock
        bit_q[c] <= !i2n[A-1];
      end
    end
  end

  // Bits move on the same system clock as the rise; filter samples the new bit
  assign link.channel_bitstream_output = bit_q;
endmodule

// ==== src/msmclk_fifo.sv ====
`timescale 1ns/1ns
module msmclk_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== src/msmclk_filt.sv ====
`timescale 1ns/1ns
module msmclk_filt #(
  parameter int OVERSAMPLING_RATIO     = msmclk_pkg::OSR_DEF,
  parameter int POR_CYC = msmclk_pkg::POR_CYC,
  parameter int EXT_DIV = 5
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // Mode control
  input  wire logic                 i_use_internal,
  // Word output
  output logic                      o_word_valid,
  output logic [1:0]                o_word_ch,
  output logic [15:0]               o_word_data,
  input  wire logic                 i_word_ready,
  // Link to the modulator
  msmclk_if.filt                    link
);
  localparam int N  = msmclk_pkg::NUM_CH;
  localparam int CW = 32;

  logic [CW-1:0] por_q;
  logic          ready_q;
  logic [7:0]    div_q;
  logic          ext_q;
  logic          mclk_q;
  logic [CW-1:0] osr_q;
  logic [N-1:0][15:0] sum_q;
  logic [N-1:0][15:0] word_q;
  logic [2:0]    emit_q;
  logic          in_ready;
  logic          rise;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on wait before trusting the streams
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      por_q   <= '0;
      ready_q <= 1'b0;
    end else if (por_q == CW'(POR_CYC)) begin
      ready_q <= 1'b1;
    end else begin
      por_q <= por_q + 1'b1;
    end
  end

  // External clock; held low while internal is chosen. EXT_DIV 5 -> 10 MHz
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_q <= 8'h00;
      ext_q <= 1'b0;
    end else if (i_use_internal) begin
      div_q <= 8'h00;
      ext_q <= 1'b0;
    end else if (div_q == 8'(EXT_DIV - 1)) begin
      div_q <= 8'h00;
      ext_q <= ~ext_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign link.external_clock_input = ext_q;
  assign link.clock_source_select  = i_use_internal;

  ////////////////////////////////////////////////////////////////////////////
  // Sample streams at output clock rise; count ones per window
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mclk_q <= 1'b0;
    end else begin
      mclk_q <= link.modulator_clock_output;
    end
  end
  assign rise = link.modulator_clock_output && !mclk_q;

  // Boxcar decimator: simple, one adder per channel, weak stopband
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osr_q  <= '0;
      sum_q  <= '0;
      word_q <= '0;
      emit_q <= 3'h0;
    end else begin
      if (rise && ready_q) begin
        for (int c = 0; c < N; c++) begin
          // One bit per channel per edge
          sum_q[c] <= (osr_q == CW'(OVERSAMPLING_RATIO - 1)) ? 16'h0000
                    : sum_q[c] + 16'(link.channel_bitstream_output[c]);
          if (osr_q == CW'(OVERSAMPLING_RATIO - 1)) begin
            word_q[c] <= sum_q[c] + 16'(link.channel_bitstream_output[c]);
          end
        end
        osr_q <= (osr_q == CW'(OVERSAMPLING_RATIO - 1)) ? '0 : osr_q + 1'b1;
        if (osr_q == CW'(OVERSAMPLING_RATIO - 1)) begin
          emit_q <= 3'h4;
        end
      end else if (emit_q != 3'h0 && in_ready) begin
        emit_q <= emit_q - 3'h1;
      end
    end
  end

  // Words dropped if the FIFO stays full for a window
  msmclk_fifo #(
    .WIDTH (18),
    .DEPTH (msmclk_pkg::FIFO_DEPTH)
  ) msmclk_fifo_inst (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (emit_q != 3'h0 && !rise),
    .i_in_data   ({2'(3'h4 - emit_q), word_q[2'(3'h4 - emit_q)]}),
    .o_in_ready  (in_ready),
    .o_out_valid (o_word_valid),
    .o_out_data  ({o_word_ch, o_word_data}),
    .i_out_ready (i_word_ready)
  );
endmodule

// ==== src/msmclk_if.sv ====
`timescale 1ns/1ns
interface msmclk_if;
  logic                        clock_source_select;
  logic                        external_clock_input;
  logic                        modulator_clock_output;
  logic [msmclk_pkg::NUM_CH-1:0] channel_bitstream_output;
  modport dev  (input  clock_source_select,
                input  external_clock_input,
                output modulator_clock_output,
                output channel_bitstream_output);
  modport filt (output clock_source_select,
                output external_clock_input,
                input  modulator_clock_output,
                input  channel_bitstream_output);
endinterface

// ==== src/msmclk_pkg.sv ====
package msmclk_pkg;
  localparam int          NUM_CH         = 4;
  // Internal oscillator in kHz; sim clock 100 MHz gives the cycle count
  localparam int          CLK_MHZ        = 100;
  localparam int          OSC_KHZ        = 20000;
  // Odd period: high phase takes the extra clock
  localparam int          OSC_PER_CYC    = (CLK_MHZ * 1000) / OSC_KHZ;
  localparam int          OSC_HI_CYC     = OSC_PER_CYC - OSC_PER_CYC / 2;
  localparam int          EXT_MIN_KHZ    = 1000;
  localparam int          EXT_MAX_KHZ    = 32000;
  localparam int          POR_US         = 600;
  localparam int          POR_CYC        = POR_US * CLK_MHZ;
  // Input code: signed level, full scale maps to 12.5..87.5 percent density
  localparam int          IN_W           = 16;
  localparam int          ACC_W          = 20;
  localparam int          OSR_DEF        = 256;
  localparam int          FIFO_DEPTH     = 8;
endpackage

// ==== test/msmclk_props.sv ====
`timescale 1ns/1ns
module msmclk_props #(
  parameter int EXT_DIV = 5
) (
  // Clock and reset
  input wire logic                          i_clk,
  input wire logic                          i_sys_rst,
  // Link
  input wire logic                          clock_source_select,
  input wire logic                          external_clock_input,
  input wire logic                          modulator_clock_output,
  input wire logic [msmclk_pkg::NUM_CH-1:0] channel_bitstream_output
);
  wire                           sel = clock_source_select;
  wire                           ext = external_clock_input;
  wire                           mck = modulator_clock_output;
  wire [msmclk_pkg::NUM_CH-1:0]  bits = channel_bitstream_output;
  logic [5:0]                    mode_q;
  logic [7:0]                    hi_q;
  logic [7:0]                    per_q;
  logic                          sel_q;
  logic                          ext_q;
  wire                           ok = mode_q == 6'h3f;
  wire                           rise = ext && !ext_q;
  //////////////////////////////////////////////////////////////////////////
  // Mode switch leaves partial periods, so judge only once settled
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= 6'h00;
      sel_q  <= 1'b0;
      ext_q  <= 1'b0;
      hi_q   <= 8'h00;
      per_q  <= 8'h00;
    end else begin
      sel_q  <= sel;
      ext_q  <= ext;
      mode_q <= (sel != sel_q) ? 6'h00 : mode_q + {5'h00, !ok};
      hi_q   <= mck ? hi_q + 8'h01 : 8'h00;
      per_q  <= rise ? 8'h01 : per_q + {7'h00, per_q != 8'hff};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_ext_static: assert property (ok && sel |-> $stable(ext))
    else $error("ext moved");
  a_int_period: assert property (
    ok && sel && $rose(mck) |-> mck[*5] ##1 !mck[*5] ##1 mck)
    else $error("int period");
  a_ext_follow: assert property (
    ok && !sel && $rose(ext) |=> $changed(mck))
    else $error("rise missed");
  a_clk_cause: assert property (
    ok && !sel && $changed(mck) |-> $past(ext) && !$past(ext, 2))
    else $error("clk no cause");
  a_high_time: assert property (
    ok && !sel && $fell(mck) |-> hi_q == 2 * EXT_DIV)
    else $error("high time");
  a_ext_range: assert property (
    ok && !sel && rise |-> per_q >= 8'h04 && per_q <= 8'h64)
    else $error("ext range");
  a_bits_edge: assert property ($changed(bits) |-> $rose(mck))
    else $error("bits edge");
  a_bits_stand: assert property (
    ok && $rose(mck) |=> $stable(bits)[*3])
    else $error("bits stand");
  c_int: cover property (ok && sel && $rose(mck));
  c_ext: cover property (ok && !sel && $rose(mck));
  c_bits: cover property ($changed(bits));
endmodule

// ==== test/tb_modulator_clock_and_bitstream_output.sv ====
`timescale 1ns/1ns
module tb_modulator_clock_and_bitstream_output;
  localparam int OVERSAMPLING_RATIO = 64;
  localparam int SET_CYC = 4 * OVERSAMPLING_RATIO * 20;
  logic                     i_clk = 1'b0;
  logic                     i_sys_rst = 1'b1;
  logic                     use_int = 1'b0;
  logic                     rdy = 1'b0;
  logic                     hold = 1'b1;
  logic                     settle = 1'b1;
  logic [3:0][15:0]         lvl = 64'h0;
  logic [63:0]              cur;
  logic [63:0]              q[$];
  logic [31:0]              rng = 32'h000012ec;
  logic                     wv;
  logic [1:0]               wch;
  logic [1:0]               pch = 2'h3;
  logic [15:0]              wd;
  logic                     wv_s = 1'b0;
  logic [1:0]               wch_s;
  logic [15:0]              wd_s;
  int                       fails = 0;
  int                       compares = 0;
  msmclk_if msmclk_if_inst ();
  msmclk_dev msmclk_dev_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ch_level(lvl), .link(msmclk_if_inst));
  msmclk_filt #(.OVERSAMPLING_RATIO(OVERSAMPLING_RATIO), .POR_CYC(100)) msmclk_filt_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_use_internal(use_int), .o_word_valid(wv),
    .o_word_ch(wch), .o_word_data(wd), .i_word_ready(rdy),
    .link(msmclk_if_inst));
  msmclk_props #(.EXT_DIV(5)) msmclk_props_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .clock_source_select(msmclk_if_inst.clock_source_select),
    .external_clock_input(msmclk_if_inst.external_clock_input),
    .modulator_clock_output(msmclk_if_inst.modulator_clock_output),
    .channel_bitstream_output(msmclk_if_inst.channel_bitstream_output));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Ones per window: half, plus 15 percent per volt
  function automatic int ones(input logic [15:0] l);
    return (OVERSAMPLING_RATIO * (4 * 32768 + 3 * $signed(l))) / (8 * 32768);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input int tol);
    compares++;
    if (((seen + tol >= exp) && (seen <= exp + tol)) !== 1'b1) begin
      fails++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Stall fills the word buffer; words of that span are not judged
  task automatic run_set(input logic mode, input int k);
    logic [15:0] tbl[4];
    int          n;
    tbl = '{16'h0000, 16'h6666, 16'h999a, rng[31:16]};
    use_int = mode;
    hold = 1'b1;
    for (n = 0; n < 4; n++) begin
      lvl[n] = tbl[(n + k) % 4];
    end
    repeat (3 * SET_CYC / 4) @(negedge i_clk);
    hold = 1'b0;
    repeat (SET_CYC / 4) @(negedge i_clk);
    repeat (8) q.push_back(lvl);
    settle = 1'b0;
    n = 0;
    while (q.size() != 0 && n < SET_CYC) begin
      @(negedge i_clk);
      n++;
    end
    check(16'(q.size()), 16'h0000, 0);
    settle = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(negedge i_clk) begin
    rng <= xs(rng);
    rdy <= rng[0] & ~hold;
    // Outputs move at the rise; snapshot them away from it
    wv_s  <= wv;
    wch_s <= wch;
    wd_s  <= wd;
  end
  always @(posedge i_clk) begin
    if (wv_s && rdy) begin
      if (!settle && q.size() != 0) begin
        cur = q.pop_front();
        check(wd_s, 16'(ones(cur[wch_s*16 +: 16])), 2);
        check(16'(wch_s), 16'(2'(pch + 2'h1)), 0);
      end
      pch = wch_s;
    end
  end
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    final_report;
  end
  initial begin
    repeat (20) @(negedge i_clk);
    i_sys_rst = 1'b0;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) begin
        run_set(m[0], k);
      end
    end
    final_report;
  end
endmodule
